// File: verilog/rcc_map.svh
// rcc_map.svh: register offsets, field positions, reset values and pin codes for the repeater config block
// assumes: included by the package user files; definitions only
`ifndef RCC_MAP_SVH
`define RCC_MAP_SVH

// ***********************************************
// register byte offsets (apb, one word each)
// ***********************************************
`define RCC_OFS_CTRL      12'h000
`define RCC_OFS_STATUS    12'h004
`define RCC_OFS_ADDR      12'h008
`define RCC_OFS_LANE0     12'h010
`define RCC_LANE_STRIDE   12'h004

// ***********************************************
// lane register fields
// ***********************************************
`define RCC_LN_BST_LSB    0
`define RCC_LN_GST_LSB    3
`define RCC_LN_DEM_LSB    5
`define RCC_LN_TDIS_BIT   8
`define RCC_LN_DEFAULT    9'h000

// ctrl register fields
`define RCC_CT_RATE_LSB   0
`define RCC_CT_IDLE_LSB   2
`define RCC_CT_OVR_BIT    4
`define RCC_CT_DEFAULT    5'h02

// three-level pin codes
`define RCC_TL_LOW        2'h0
`define RCC_TL_HIGH       2'h1
`define RCC_TL_FLOAT      2'h2

// rate codes
`define RCC_RATE_GEN1     2'h0
`define RCC_RATE_GEN2     2'h1
`define RCC_RATE_AUTO     2'h2

`endif

// File: verilog/rcc_pkg.sv
// rcc_pkg.sv: types shared by the repeater config block
// assumes: rcc_map.svh holds the numbers
package rcc_pkg;
  typedef logic [1:0] rcc_tl_t;
  typedef logic [1:0] rcc_gst_t;
  typedef logic [2:0] rcc_bst_t;
  typedef logic [2:0] rcc_dem_t;
  typedef logic [1:0] rcc_rate_t;
endpackage : rcc_pkg

// File: verilog/rcc_eq_decode.sv
// rcc_eq_decode.sv: decode of the two three-level eq pins into gain-stage and boost codes
// assumes: pin levels are already resolved to low, high or float
`timescale 1ns/1ps
`include "rcc_map.svh"

module rcc_eq_decode
  import rcc_pkg::*;
(
  input  wire rcc_pkg::rcc_tl_t  eq_hi,
  input  wire rcc_pkg::rcc_tl_t  eq_lo,
  output rcc_pkg::rcc_gst_t      gain_stage_code,
  output rcc_pkg::rcc_bst_t      boost_level_code
);

  always_comb
  begin
    gain_stage_code  = 2'h0;
    boost_level_code = 3'h0;
    case ({eq_hi, eq_lo})
      {`RCC_TL_FLOAT, `RCC_TL_FLOAT}: {gain_stage_code, boost_level_code} = {2'h0, 3'h0};  // [RULE14]
      {`RCC_TL_HIGH,  `RCC_TL_HIGH }: {gain_stage_code, boost_level_code} = {2'h1, 3'h2};  // [RULE15]
      {`RCC_TL_LOW,   `RCC_TL_LOW  }: {gain_stage_code, boost_level_code} = {2'h2, 3'h0};  // [RULE16]
      {`RCC_TL_FLOAT, `RCC_TL_LOW  }: {gain_stage_code, boost_level_code} = {2'h2, 3'h2};  // [RULE17]
      {`RCC_TL_FLOAT, `RCC_TL_HIGH }: {gain_stage_code, boost_level_code} = {2'h2, 3'h5};  // [RULE18]
      {`RCC_TL_LOW,   `RCC_TL_HIGH }: {gain_stage_code, boost_level_code} = {2'h2, 3'h7};  // [RULE19]
      {`RCC_TL_HIGH,  `RCC_TL_LOW  }: {gain_stage_code, boost_level_code} = {2'h3, 3'h1};  // [RULE20]
      {`RCC_TL_LOW,   `RCC_TL_FLOAT}: {gain_stage_code, boost_level_code} = {2'h3, 3'h3};  // [RULE20]
      {`RCC_TL_HIGH,  `RCC_TL_FLOAT}: {gain_stage_code, boost_level_code} = {2'h3, 3'h5};  // [RULE20]
      default:                        {gain_stage_code, boost_level_code} = {2'h0, 3'h0};
    endcase
  end

endmodule : rcc_eq_decode

// File: verilog/rcc_top.sv
// rcc_top.sv: configuration control of a four-lane repeater: pin mode, register mode, apb slave
// assumes: pins synchronous to pclk; each three-level pin arrives as drive_en/level pair from the pad
//
// Function
// RULE1 - mode select low means pin mode, high means register mode.
// RULE2 - pin mode takes eq and de-emphasis from pins, side A and B separately.
// RULE3 - nonzero de-emphasis raises output swing to the level tied to it.
// RULE4 - pin mode termination pins choose 50 ohm or high-impedance termination.
// RULE5 - pin mode rate input chooses forced gen1, forced gen2 or auto detect.
// RULE6 - register mode sets eq, de-emphasis, termination disable per lane.
// RULE7 - entering register mode moves rate, eq, de-emphasis to registers at once.
// RULE8 - register mode turns the four eq/de-emphasis pins into address straps.
// RULE9 - other pins act until override set, then ignored until mode select low.
// RULE10 - registers go to defaults at reset and whenever mode select is low.
// RULE11 - cable-absent in register mode keeps all register contents.
// RULE12 - eq is a two-bit gain stage plus three-bit boost, all via registers.
// RULE13 - each select pin is decoded as high, low or floating.
// RULE14 - both eq pins floating gives gain 00 boost 000.
// RULE15 - both eq pins high gives gain 01 boost 010.
// RULE16 - both eq pins low gives gain 10 boost 000.
// RULE17 - upper float, lower low gives gain 10 boost 010.
// RULE18 - upper float, lower high gives gain 10 boost 101.
// RULE19 - upper low, lower high gives gain 10 boost 111.
// RULE20 - gain 11 with boost 001, 011, 101 for the three remaining pin pairs.
// RULE21 - cable-absent high means low power, low means normal operation.
// RULE22 - in register mode the rate pin is ignored, rate follows register.
// RULE23 - host uses the strap-formed slave address; device answers only that address.
`timescale 1ns/1ps
`include "rcc_map.svh"

module rcc_top
  import rcc_pkg::*;
#(
  parameter int LANES = 4
)
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    smbus_mode_select,
  input  wire logic [1:0]              eq_select_high_pin_drv,
  input  wire logic [1:0]              eq_select_high_pin_lvl,
  input  wire logic [1:0]              eq_select_low_pin_drv,
  input  wire logic [1:0]              eq_select_low_pin_lvl,
  input  wire logic [3:0]              deemph_select_pins_drv,
  input  wire logic [3:0]              deemph_select_pins_lvl,
  input  wire logic                    rate_pin_drv,
  input  wire logic                    rate_pin_lvl,
  input  wire logic [1:0]              termination_ctrl_pins,
  input  wire logic                    idle_ctrl_pin,
  input  wire logic                    cable_absent_pin,
  input  wire logic [6:0]              smbus_target_addr,
  output logic      [3:0]              smbus_addr_straps,
  output logic                         smbus_addr_match,
  output logic      [2*LANES-1:0]      gain_stage_code,
  output logic      [3*LANES-1:0]      boost_level_code,
  output logic      [3*LANES-1:0]      deemph_code,
  output logic      [LANES-1:0]        output_swing_boost,
  output logic      [LANES-1:0]        termination_high_z,
  output logic      [1:0]              rate_code,
  output logic                         idle_manual,
  output logic                         low_power
);
  import rcc_pkg::*;

  // ***********************************************
  // three-level pin resolve
  // ***********************************************
  function automatic rcc_tl_t tl(input logic drv, input logic lvl);
    tl = drv ? (lvl ? `RCC_TL_HIGH : `RCC_TL_LOW) : `RCC_TL_FLOAT;  // [RULE13]
  endfunction : tl

  rcc_tl_t   eqh_a;
  rcc_tl_t   eqh_b;
  rcc_tl_t   eql_a;
  rcc_tl_t   eql_b;
  rcc_gst_t  pin_gst_a;
  rcc_gst_t  pin_gst_b;
  rcc_bst_t  pin_bst_a;
  rcc_bst_t  pin_bst_b;
  rcc_dem_t  pin_dem_a;
  rcc_dem_t  pin_dem_b;
  rcc_rate_t pin_rate;

  assign eqh_a = tl(eq_select_high_pin_drv[0], eq_select_high_pin_lvl[0]);
  assign eqh_b = tl(eq_select_high_pin_drv[1], eq_select_high_pin_lvl[1]);
  assign eql_a = tl(eq_select_low_pin_drv[0], eq_select_low_pin_lvl[0]);
  assign eql_b = tl(eq_select_low_pin_drv[1], eq_select_low_pin_lvl[1]);

  // ***********************************************
  // per-side eq decode
  // ***********************************************
  // side a and b decoded separately
  rcc_eq_decode u_eq_a (  // [RULE2]
    .eq_hi            (eqh_a),
    .eq_lo            (eql_a),
    .gain_stage_code  (pin_gst_a),
    .boost_level_code (pin_bst_a)
  );

  rcc_eq_decode u_eq_b (  // [RULE2]
    .eq_hi            (eqh_b),
    .eq_lo            (eql_b),
    .gain_stage_code  (pin_gst_b),
    .boost_level_code (pin_bst_b)
  );

  // ***********************************************
  // de-emphasis and rate pins
  // ***********************************************
  // de-emphasis code of {dem1,dem0}: driven pairs give 0..3, pairs with one float pin give 4..7
  function automatic rcc_dem_t dem_of(input rcc_tl_t d1, input rcc_tl_t d0);
    case ({d1, d0})
      {`RCC_TL_LOW,   `RCC_TL_LOW  }: dem_of = 3'h0;
      {`RCC_TL_LOW,   `RCC_TL_HIGH }: dem_of = 3'h1;
      {`RCC_TL_HIGH,  `RCC_TL_LOW  }: dem_of = 3'h2;
      {`RCC_TL_HIGH,  `RCC_TL_HIGH }: dem_of = 3'h3;
      {`RCC_TL_LOW,   `RCC_TL_FLOAT}: dem_of = 3'h4;
      {`RCC_TL_HIGH,  `RCC_TL_FLOAT}: dem_of = 3'h5;
      {`RCC_TL_FLOAT, `RCC_TL_LOW  }: dem_of = 3'h6;
      {`RCC_TL_FLOAT, `RCC_TL_HIGH }: dem_of = 3'h7;
      default:                        dem_of = 3'h0;  // reserved pair falls back to none
    endcase
  endfunction : dem_of

  assign pin_dem_a = dem_of(tl(deemph_select_pins_drv[1], deemph_select_pins_lvl[1]),
                            tl(deemph_select_pins_drv[0], deemph_select_pins_lvl[0]));  // [RULE2]
  assign pin_dem_b = dem_of(tl(deemph_select_pins_drv[3], deemph_select_pins_lvl[3]),
                            tl(deemph_select_pins_drv[2], deemph_select_pins_lvl[2]));  // [RULE2]
  assign pin_rate  = tl(rate_pin_drv, rate_pin_lvl);  // [RULE5]

  // ***********************************************
  // registers
  // ***********************************************
  logic [8:0]  lane_r [LANES];
  logic [4:0]  ctrl_r;
  logic        ovr_r;
  logic        reg_mode;
  logic        acc;
  logic        wr;
  logic        hit_lane;
  logic [1:0]  lane_idx;
  logic [11:0] lane_ofs;
  logic        mapped;

  // ***********************************************
  // mode and address decode
  // ***********************************************
  assign reg_mode = smbus_mode_select;  // [RULE1]
  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign lane_ofs = paddr - `RCC_OFS_LANE0;
  assign hit_lane = (paddr >= `RCC_OFS_LANE0) && (lane_ofs < 12'(LANES * 4)) && (paddr[1:0] == 2'h0);
  assign lane_idx = lane_ofs[3:2];
  assign mapped   = hit_lane || paddr == `RCC_OFS_CTRL || paddr == `RCC_OFS_STATUS
                    || paddr == `RCC_OFS_ADDR;

  // ***********************************************
  // lane registers
  // ***********************************************
  // cable-absent does not touch these; only reset and mode-select low clear them
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++)
    begin : g_lane
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          lane_r[gi] <= `RCC_LN_DEFAULT;  // [RULE10]
        else if (!reg_mode)
          lane_r[gi] <= `RCC_LN_DEFAULT;  // [RULE10] [RULE11]
        else if (wr && hit_lane && lane_idx == 2'(gi))
          lane_r[gi] <= pwdata[8:0];  // [RULE6] [RULE12]
      end
    end
  endgenerate

  // ***********************************************
  // control register and override
  // ***********************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= `RCC_CT_DEFAULT;
    else if (!reg_mode)
      ctrl_r <= `RCC_CT_DEFAULT;  // [RULE10]
    else if (wr && paddr == `RCC_OFS_CTRL)
      ctrl_r <= pwdata[4:0];
  end

  // override is sticky until mode select drops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovr_r <= 1'b0;
    else if (!reg_mode)
      ovr_r <= 1'b0;  // [RULE9]
    else if (wr && paddr == `RCC_OFS_CTRL && pwdata[`RCC_CT_OVR_BIT])
      ovr_r <= 1'b1;  // [RULE9]
  end

  // ***********************************************
  // read mux
  // ***********************************************
  // kept apart so prdata is one plain flop loaded in the setup cycle
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = 32'h0;
    if (hit_lane)
      rd_word = {23'h0, lane_r[lane_idx]};
    else if (paddr == `RCC_OFS_CTRL)
      rd_word = {27'h0, ovr_r, ctrl_r[3:0]};
    else if (paddr == `RCC_OFS_STATUS)
      rd_word = {28'h0, cable_absent_pin, low_power, reg_mode, ovr_r};
    else if (paddr == `RCC_OFS_ADDR)
      rd_word = {28'h0, smbus_addr_straps};
  end

  // ***********************************************
  // apb slave: zero wait, unmapped gives pslverr
  // ***********************************************
  // no wait states: every transfer takes exactly setup plus one access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable && !pwrite)
        prdata <= rd_word;
    end
  end

  // ***********************************************
  // output selection
  // ***********************************************
  // side a drives lanes 0..1, side b lanes 2..3 in pin mode
  generate
    for (gi = 0; gi < LANES; gi++)
    begin : g_out
      logic     side_b;
      rcc_dem_t dem;
      assign side_b = (gi >= LANES / 2);
      // register mode switches dem in the same cycle; the output flops take it on the next pclk edge
      assign dem = reg_mode ? lane_r[gi][`RCC_LN_DEM_LSB +: 3]
                            : (side_b ? pin_dem_b : pin_dem_a);  // [RULE7]
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          gain_stage_code[2*gi +: 2]  <= 2'h0;
          boost_level_code[3*gi +: 3] <= 3'h0;
          deemph_code[3*gi +: 3]      <= 3'h0;
          output_swing_boost[gi]      <= 1'b0;
          termination_high_z[gi]      <= 1'b0;
        end
        else
        begin
          gain_stage_code[2*gi +: 2]  <= reg_mode ? lane_r[gi][`RCC_LN_GST_LSB +: 2]
                                                  : (side_b ? pin_gst_b : pin_gst_a);  // [RULE7] [RULE12]
          boost_level_code[3*gi +: 3] <= reg_mode ? lane_r[gi][`RCC_LN_BST_LSB +: 3]
                                                  : (side_b ? pin_bst_b : pin_bst_a);  // [RULE7] [RULE12]
          deemph_code[3*gi +: 3]      <= dem;
          output_swing_boost[gi]      <= (dem != 3'h0);  // [RULE3]
          if (reg_mode && ovr_r)
            termination_high_z[gi] <= lane_r[gi][`RCC_LN_TDIS_BIT];  // [RULE6] [RULE9]
          else
            termination_high_z[gi] <= side_b ? termination_ctrl_pins[1] : termination_ctrl_pins[0];  // [RULE4]
        end
      end
    end
  endgenerate

  // ***********************************************
  // rate, idle and power
  // ***********************************************
  // low power only follows the pin; register contents are left alone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rate_code   <= `RCC_RATE_AUTO;
      idle_manual <= 1'b0;
      low_power   <= 1'b0;
    end
    else
    begin
      rate_code   <= reg_mode ? ctrl_r[`RCC_CT_RATE_LSB +: 2] : pin_rate;  // [RULE5] [RULE22]
      idle_manual <= (reg_mode && ovr_r) ? ctrl_r[`RCC_CT_IDLE_LSB] : idle_ctrl_pin;  // [RULE9]
      low_power   <= cable_absent_pin;  // [RULE21]
    end
  end

  // ***********************************************
  // smbus address straps
  // ***********************************************
  // straps come from side a pins only; side b pins are left unused in register mode
  logic [3:0] straps;
  assign straps = {deemph_select_pins_lvl[1], deemph_select_pins_lvl[0],
                   eq_select_low_pin_lvl[0], eq_select_high_pin_lvl[0]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      smbus_addr_straps <= 4'h0;
      smbus_addr_match  <= 1'b0;
    end
    else
    begin
      smbus_addr_straps <= reg_mode ? straps : 4'h0;  // [RULE8]
      smbus_addr_match  <= reg_mode && (smbus_target_addr[3:0] == straps)
                           && (smbus_target_addr[6:4] == 3'h0);  // [RULE23]
    end
  end

endmodule : rcc_top

// File: tb/rcc_top_assertions.sv
// rcc_top_assertions.sv: port-level checks of the repeater config block
// assumes: bound to rcc_top; one clock, async active-low reset
`timescale 1ns/1ps
module rcc_top_checker #(
  parameter int LANES = 4
)
(
  input wire logic [0:0]         pclk,
  input wire logic [0:0]         presetn,
  input wire logic [0:0]         psel,
  input wire logic [0:0]         penable,
  input wire logic [0:0]         pready,
  input wire logic [0:0]         smbus_mode_select,
  input wire logic [1:0]         eq_select_high_pin_lvl,
  input wire logic [1:0]         eq_select_low_pin_lvl,
  input wire logic [3:0]         deemph_select_pins_lvl,
  input wire logic [0:0]         rate_pin_drv,
  input wire logic [0:0]         rate_pin_lvl,
  input wire logic [1:0]         termination_ctrl_pins,
  input wire logic [0:0]         cable_absent_pin,
  input wire logic [6:0]         smbus_target_addr,
  input wire logic [3:0]         smbus_addr_straps,
  input wire logic [0:0]         smbus_addr_match,
  input wire logic [3*LANES-1:0] deemph_code,
  input wire logic [LANES-1:0]   output_swing_boost,
  input wire logic [LANES-1:0]   termination_high_z,
  input wire logic [1:0]         rate_code,
  input wire logic [0:0]         low_power
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [LANES-1:0] dem_nz;
  always_comb
  begin
    for (int i = 0; i < LANES; i++)
      dem_nz[i] = |deemph_code[3*i+:3];
  end
  a_ready_zero_wait: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
  a_rate_forced: assert property (!smbus_mode_select && rate_pin_drv |=>
    rate_code == {1'b0, $past(rate_pin_lvl)})
    else $error("forced rate not applied");
  a_swing_follows: assert property (output_swing_boost == dem_nz)
    else $error("swing does not track de-emphasis");
  a_straps_idle: assert property (!smbus_mode_select |=> smbus_addr_straps == 4'h0 && !smbus_addr_match)
    else $error("address straps active in pin mode");
  a_straps_live: assert property (smbus_mode_select |=> smbus_addr_straps ==
    $past({deemph_select_pins_lvl[1:0], eq_select_low_pin_lvl[0], eq_select_high_pin_lvl[0]}))
    else $error("address straps wrong");
  a_term_pins: assert property (!smbus_mode_select && !$past(smbus_mode_select) |=>
    termination_high_z == {{2{$past(termination_ctrl_pins[1])}}, {2{$past(termination_ctrl_pins[0])}}})
    else $error("termination does not follow pins");
  a_power_follow: assert property (cable_absent_pin |=> low_power)
    else $error("low power not entered");
  a_match_off: assert property (smbus_target_addr[6:4] != 3'h0 |=> !smbus_addr_match)
    else $error("foreign address matched");
endmodule : rcc_top_checker

bind rcc_top rcc_top_checker #(.LANES(LANES)) u_chk (.pclk, .presetn, .psel, .penable, .pready, .smbus_mode_select,
  .eq_select_high_pin_lvl, .eq_select_low_pin_lvl, .deemph_select_pins_lvl, .rate_pin_drv, .rate_pin_lvl,
  .termination_ctrl_pins, .cable_absent_pin, .smbus_target_addr, .smbus_addr_straps, .smbus_addr_match,
  .deemph_code, .output_swing_boost, .termination_high_z, .rate_code, .low_power);

// File: tb/rcc_strap_model.sv
// rcc_strap_model.sv: board strap pins, codes 0 low, 1 high, 2 float
// assumes: pin i uses tl[2i+:2]; a floating pin is not driven
`timescale 1ns/1ps
module rcc_strap_model
(
  input  wire logic        pclk,
  input  wire logic [17:0] tl,
  output logic      [8:0]  drv,
  output logic      [8:0]  lvl
);
  logic tog_r = 1'b0;
  // a floating pin has no logic level, so show one that keeps changing
  always_ff @(posedge pclk)
  begin
    tog_r <= ~tog_r;
  end
  always_comb
  begin
    for (int i = 0; i < 9; i++)
    begin
      drv[i] = tl[2*i+:2] != 2'h2;
      lvl[i] = drv[i] ? tl[2*i] : tog_r ^ i[0];
    end
  end
endmodule : rcc_strap_model

// File: tb/rcc_top_tb.sv
// rcc_top_tb.sv: self-checking bench of the repeater config block
// assumes: design, strap model and checker compiled first
`timescale 1ns/1ps
`include "rcc_map.svh"
module rcc_top_tb;
  import rcc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic        smbus_mode_select, idle_ctrl_pin, cable_absent_pin, smbus_addr_match, idle_manual, low_power;
  logic [11:0] paddr, boost_level_code, deemph_code, eqv;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0]  termination_ctrl_pins, rate_code;
  logic [6:0]  smbus_target_addr;
  logic [3:0]  smbus_addr_straps, output_swing_boost, termination_high_z;
  logic [7:0]  gain_stage_code;
  logic [17:0] tl;
  logic [8:0]  drv, lvl;
  int          failures, cmp_count, seed, lane_m[4];
  logic [4:0]  eq_tab[9] = '{5'h10, 5'h17, 5'h1b, 5'h19, 5'h0a, 5'h1d, 5'h12, 5'h15, 5'h00};
  logic [5:0]  dem_tab[3] = '{6'h04, 6'h13, 6'h36};
  rcc_top #(.LANES(4)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .smbus_mode_select, .eq_select_high_pin_drv(drv[1:0]), .eq_select_high_pin_lvl(lvl[1:0]),
    .eq_select_low_pin_drv(drv[3:2]), .eq_select_low_pin_lvl(lvl[3:2]), .deemph_select_pins_drv(drv[7:4]),
    .deemph_select_pins_lvl(lvl[7:4]), .rate_pin_drv(drv[8]), .rate_pin_lvl(lvl[8]), .termination_ctrl_pins,
    .idle_ctrl_pin, .cable_absent_pin, .smbus_target_addr, .smbus_addr_straps, .smbus_addr_match,
    .gain_stage_code, .boost_level_code, .deemph_code, .output_swing_boost, .termination_high_z, .rate_code,
    .idle_manual, .low_power);
  rcc_strap_model u_straps (.pclk, .tl, .drv, .lvl);
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk_out(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t port got %h exp %h", $time, got, exp);
    end
  endtask : chk_out
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'h0;
    if (pready !== 1'b1)
    begin
      failures++;
      complete_run();
    end
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    cmp_count++;
    if (rerr !== ee || (!ee && rdat !== e))
    begin
      failures++;
      $display("MISMATCH %0t read %h got %h exp %h", $time, a, rdat, e);
    end
  endtask : rd_chk
  task automatic settle();
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask : settle
  task automatic chk_lanes();
    for (int i = 0; i < 4; i++)
    begin
      chk_out(12'(gain_stage_code[2*i+:2]), 12'(lane_m[i] >> 3 & 3));
      chk_out(12'(boost_level_code[3*i+:3]), 12'(lane_m[i] & 7));
      chk_out(12'(deemph_code[3*i+:3]), 12'(lane_m[i] >> 5 & 7));
      chk_out(12'(output_swing_boost[i]), 12'((lane_m[i] >> 5 & 7) != 0));
      rd_chk(12'(`RCC_OFS_LANE0 + 4 * i), 32'(lane_m[i]), 1'b0);
    end
  endtask : chk_lanes
  initial
  begin
    {failures, cmp_count, seed} = {32'h0, 32'h0, 32'h47};
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {smbus_mode_select, idle_ctrl_pin, cable_absent_pin, termination_ctrl_pins, smbus_target_addr} = '0;
    tl = {9{2'h2}};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // writes in pin mode must not land
    apb(1'b1, `RCC_OFS_LANE0, 32'h1ff);
    rd_chk(`RCC_OFS_LANE0, 32'h0, 1'b0);
    rd_chk(`RCC_OFS_CTRL, 32'h2, 1'b0);
    $display("test reset done");
    for (int k = 0; k < 9; k++)
    begin
      @(posedge pclk);
      {tl[1:0], tl[5:4], tl[3:2], tl[7:6]} <= {2'(k / 3), 2'(k % 3), 2'((8 - k) / 3), 2'((8 - k) % 3)};
      settle();
      for (int i = 0; i < 4; i++)
      begin
        eqv = {7'h0, gain_stage_code[2*i+:2], boost_level_code[3*i+:3]};
        chk_out(eqv, 12'(eq_tab[i < 2 ? k : 8 - k]));
      end
    end
    $display("test eq pins done");
    for (int r = 0; r < 3; r++)
    begin
      @(posedge pclk);
      {tl[17:16], tl[15:8]} <= {2'(r), 2'(r), 2'(2 - r), 2'(r), 2'h0};
      {termination_ctrl_pins, idle_ctrl_pin, cable_absent_pin} <= {2'($random(seed)), r[0], r[0]};
      settle();
      chk_out(12'(rate_code), 12'(r));
      chk_out(12'(termination_high_z), 12'({{2{termination_ctrl_pins[1]}}, {2{termination_ctrl_pins[0]}}}));
      chk_out(12'(low_power), 12'(r[0]));
      chk_out(deemph_code, {{2{dem_tab[r][2:0]}}, {2{dem_tab[r][5:3]}}});
      chk_out(12'(output_swing_boost), 12'({{2{|dem_tab[r][2:0]}}, {2{|dem_tab[r][5:3]}}}));
      chk_out(12'(idle_manual), 12'(r[0]));
    end
    $display("test rate and termination done");
    @(posedge pclk);
    smbus_mode_select <= 1'b1;
    {tl[17:16], tl[1:0], tl[5:4], tl[9:8], tl[11:10]} <= {2'h1, 2'h1, 2'h0, 2'h1, 2'h0};
    smbus_target_addr <= 7'h05;
    settle();
    chk_out(12'(smbus_addr_straps), 12'h5);
    chk_out(12'(smbus_addr_match), 12'h1);
    chk_out(12'(rate_code), 12'h2);
    for (int i = 0; i < 4; i++)
    begin
      lane_m[i] = $random(seed) & 32'h1ff;
      apb(1'b1, 12'(`RCC_OFS_LANE0 + 4 * i), 32'(lane_m[i]));
    end
    apb(1'b1, `RCC_OFS_CTRL, 32'h0);
    smbus_target_addr <= 7'h15;
    settle();
    chk_lanes();
    chk_out(12'(rate_code), 12'h0);
    chk_out(12'(smbus_addr_match), 12'h0);
    @(posedge pclk);
    {cable_absent_pin, termination_ctrl_pins} <= 3'h5;
    settle();
    chk_out(12'(low_power), 12'h1);
    chk_out(12'(termination_high_z), 12'h3);
    chk_lanes();
    $display("test register mode done");
    @(posedge pclk);
    cable_absent_pin <= 1'b0;
    apb(1'b1, `RCC_OFS_CTRL, 32'h10);
    {termination_ctrl_pins, idle_ctrl_pin} <= 3'h5;
    settle();
    rd_chk(`RCC_OFS_STATUS, 32'h3, 1'b0);
    chk_out(12'(idle_manual), 12'h0);
    chk_out(12'(termination_high_z), 12'({lane_m[3][8], lane_m[2][8], lane_m[1][8], lane_m[0][8]}));
    @(posedge pclk);
    smbus_mode_select <= 1'b0;
    repeat (2) @(posedge pclk);
    smbus_mode_select <= 1'b1;
    settle();
    rd_chk(`RCC_OFS_LANE0 + 12'h4, 32'h0, 1'b0);
    rd_chk(`RCC_OFS_STATUS, 32'h2, 1'b0);
    chk_out(12'(idle_manual), 12'h1);
    chk_out(12'(termination_high_z), 12'hc);
    rd_chk(12'h0fc, 32'h0, 1'b1);
    $display("test override and mode exit done");
    complete_run();
  end
endmodule : rcc_top_tb
